// [rtl/smc_pkg.sv]
// Purpose: Shared constants and types for the standby mode controller
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   Control fields are 8 bits wide, upper bus bits read zero
`default_nettype none
package smc_pkg;
  // Register byte addresses
  localparam logic [3:0] OFF_CTRL1  = 4'h0;
  localparam logic [3:0] OFF_CTRL2  = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;

  // standby_control_1 field positions
  localparam int C1_STOP  = 7;
  localparam int C1_RELEASE_SELECT  = 6;
  localparam int C1_PORT  = 4;
  localparam int C1_WUT_L = 2;
  localparam int C1_WUT_H = 3;
  // standby_control_2 field positions
  localparam int C2_FIXED = 7;
  localparam int C2_IDLE  = 4;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h80;

  // Warm-up lengths in main clock periods
  localparam int WARM_LONG_CYC  = 3 * (2 ** 19);
  localparam int WARM_SHORT_CYC = 2 ** 19;
  localparam int WARM_W         = 21;

  // Watchdog latch index in the pending vector
  localparam int WDT_IRQ_BIT = 2;

  typedef enum logic [1:0]
  {
    WUT_LONG  = 2'h0,
    WUT_SHORT = 2'h1
  } smc_wut_t;

  // Stored fields of standby_control_1
  typedef struct packed
  {
    logic     releaseSelect;
    logic     portDriveDuringHalt;
    smc_wut_t warmupSelect;
  } smc_ctrl1_t;

  // Control outputs toward the rest of the chip
  typedef struct packed
  {
    logic oscRun;
    logic cpuHalt;
    logic wdtHalt;
    logic portHiZ;
  } smc_hold_t;
endpackage
`default_nettype wire

// [rtl/smc_standby_ctrl.sv]
// Purpose: Standby controller, full-halt and CPU-idle entry and release
// Assumes: All inputs synchronous to core_clk; rst_n is the reset pin
// Notes:   Registers reached over Avalon-MM with one wait state
//
// Our own choices: the address map and the Avalon-MM register port.
`default_nettype none
module smc_standby_ctrl
#(
  parameter int WARM_LONG  = smc_pkg::WARM_LONG_CYC,
  parameter int WARM_SHORT = smc_pkg::WARM_SHORT_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Wake pin and interrupt state
  input  wire logic        wakePin,
  input  wire logic [15:0] irqPendingLatch,
  input  wire logic [15:0] sourceIrqEnable,
  input  wire logic        masterIrqEnable,
  // Controls toward the chip
  output smc_pkg::smc_hold_t hold,
  output logic             dividerClear,
  output logic             resumeNext,
  output logic             irqService,
  output logic [1:0]       modeState
);

  typedef enum logic [1:0]
  {
    ST_NORMAL,
    ST_HALT,
    ST_WARMUP,
    ST_IDLE
  } smc_state_t;

  smc_state_t                  state_q;
  smc_pkg::smc_ctrl1_t         ctrl1_q;
  logic                        relEff_q;
  logic                        relPend_q;
  logic                        wakePrev_q;
  logic [smc_pkg::WARM_W-1:0]  warmCnt_q;
  logic                        ack_q;
  logic [31:0]                 rdata_q;
  logic                        divClr_q;
  logic                        resume_q;
  logic                        service_q;

  logic                        wrTake;
  logic                        wakeRise;
  logic                        stopReq;
  logic                        idleReq;
  logic                        irqWake;
  logic                        warmDone;
  logic [7:0]                  ctrl1Read;
  logic [7:0]                  ctrl2Read;
  logic [7:0]                  statusRead;
  smc_pkg::smc_wut_t           warmSel;

  // Mode map as seen by the rest of the chip:
  //   ST_NORMAL  CPU and peripherals run, bus writes start a standby mode
  //   ST_HALT    oscillator off, everything frozen, waits for the wake pin
  //   ST_WARMUP  oscillator back on, CPU still frozen while it settles
  //   ST_IDLE    CPU and watchdog frozen, peripherals and clock run
  // Only ST_NORMAL accepts a new start write; a start bit written in any
  // other mode is dropped, since the CPU cannot execute there anyway.
  // Leaving a standby mode never resets CPU state: the hold outputs only
  // freeze it, and resumeNext tells the CPU to go on with the next
  // instruction. A reset pin low ends every mode on the next edge.
  // The wake pin and interrupt inputs are taken as already synchronous;
  // a raw pin must be synchronised before it reaches this block.

  // Byte lane 0 carries every control field
  function automatic logic lane0Hit(input logic [3:0] off);
    lane0Hit = wrTake && (avs_address == off) && avs_byteenable[0];
  endfunction

  // Warm-up length for the selected code, reserved codes use the short one
  function automatic logic [smc_pkg::WARM_W-1:0] warmLen(
    input smc_pkg::smc_wut_t sel);
    if (sel == smc_pkg::WUT_LONG)
      warmLen = smc_pkg::WARM_W'(WARM_LONG - 1);
    else
      warmLen = smc_pkg::WARM_W'(WARM_SHORT - 1);
  endfunction

  // Bus timing: a request is seen with ack_q low, so waitrequest stands
  // high for that first cycle. ack_q rises at the next edge, waitrequest
  // drops and the access completes at the edge after. Writes only land
  // on that completing edge, so a master that drops its request early
  // never half-writes a field. Each access costs two cycles, which keeps
  // read data registered at the price of one extra wait state.
  // Start bits act on the same completing edge as the stored fields.

  // One wait state: request waits until ack_q, then completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wrTake  = avs_write && ack_q;
  assign stopReq = lane0Hit(smc_pkg::OFF_CTRL1)
                   && avs_writedata[smc_pkg::C1_STOP];
  assign idleReq = lane0Hit(smc_pkg::OFF_CTRL2)
                   && avs_writedata[smc_pkg::C2_IDLE];
  assign wakeRise = wakePin && !wakePrev_q;
  assign irqWake  = |(irqPendingLatch & sourceIrqEnable);
  assign warmDone = (warmCnt_q == '0);

  // Bus handshake, released after the completing edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  // Stored configuration fields of standby_control_1
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl1_q.releaseSelect       <= smc_pkg::CTRL1_RST[smc_pkg::C1_RELEASE_SELECT];
      ctrl1_q.portDriveDuringHalt <= smc_pkg::CTRL1_RST[smc_pkg::C1_PORT];
      ctrl1_q.warmupSelect        <= smc_pkg::smc_wut_t'(
        smc_pkg::CTRL1_RST[smc_pkg::C1_WUT_H:smc_pkg::C1_WUT_L]);
    end
    else if (lane0Hit(smc_pkg::OFF_CTRL1))
    begin
      ctrl1_q.releaseSelect       <= avs_writedata[smc_pkg::C1_RELEASE_SELECT];
      ctrl1_q.portDriveDuringHalt <= avs_writedata[smc_pkg::C1_PORT];
      ctrl1_q.warmupSelect        <= smc_pkg::smc_wut_t'(
        avs_writedata[smc_pkg::C1_WUT_H:smc_pkg::C1_WUT_L]);
    end
  end

  // Wake pin history for edge detection
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wakePrev_q <= 1'b0;
    else
      wakePrev_q <= wakePin;
  end

  // Effective release method; edge to level waits for a rising edge.
  // The stored field reads back at once, the effective method lags it,
  // so software can poll the status view to see the switch complete.
  // Level back to edge needs no edge and takes effect at once.
  // A write and a rising edge in one cycle: the write wins, and the
  // switch stays pending for the next edge.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      relEff_q  <= 1'b0;
      relPend_q <= 1'b0;
    end
    else if (lane0Hit(smc_pkg::OFF_CTRL1))
    begin
      if (!avs_writedata[smc_pkg::C1_RELEASE_SELECT])
      begin
        relEff_q  <= 1'b0;
        relPend_q <= 1'b0;
      end
      else if (!relEff_q)
        relPend_q <= 1'b1;
    end
    else if (relPend_q && wakeRise)
    begin
      relEff_q  <= 1'b1;
      relPend_q <= 1'b0;
    end
  end

  // Mode sequencer; synchronous reset ends any standby mode at once.
  // A stop write in level mode with the pin already high skips the halt
  // state, so the oscillator is never switched off for a wake that has
  // already happened. In edge mode a high pin is ignored at entry: only
  // a fresh rising edge releases. The watchdog latch blocks idle entry
  // so its service is not delayed behind a sleep it would have ended.
  // Interrupts are not looked at in halt or warm-up; only the wake pin
  // or the reset pin can leave halt.
  // Stop and idle starts sit in different registers, so one write can
  // never ask for both.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= ST_NORMAL;
    else
    begin
      unique case (state_q)
        ST_NORMAL:
        begin
          if (stopReq)
          begin
            if (relEff_q && wakePin)
              state_q <= ST_WARMUP;
            else
              state_q <= ST_HALT;
          end
          else if (idleReq
                   && !irqPendingLatch[smc_pkg::WDT_IRQ_BIT])
            state_q <= ST_IDLE;
        end
        ST_HALT:
        begin
          if (relEff_q && wakePin)
            state_q <= ST_WARMUP;
          else if (!relEff_q && wakeRise)
            state_q <= ST_WARMUP;
        end
        ST_WARMUP:
        begin
          // Wake pin is not looked at here, so a low pin cannot re-halt
          if (warmDone)
            state_q <= ST_NORMAL;
        end
        ST_IDLE:
        begin
          if (irqWake)
            state_q <= ST_NORMAL;
        end
      endcase
    end
  end

  // Length select for the next warm-up. A stop write that goes straight
  // to warm-up also carries the new select, and the stored field only
  // updates on that same edge, so the written code must win here or the
  // first warm-up would use the stale length.
  always_comb
  begin
    if (lane0Hit(smc_pkg::OFF_CTRL1))
      warmSel = smc_pkg::smc_wut_t'(
        avs_writedata[smc_pkg::C1_WUT_H:smc_pkg::C1_WUT_L]);
    else
      warmSel = ctrl1_q.warmupSelect;
  end

  // Warm-up down-counter, loaded whenever warm-up is entered.
  // Counting down to zero makes the end test a single compare, and the
  // reload outside warm-up keeps it ready for a direct entry.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      warmCnt_q <= '0;
    else if (state_q != ST_WARMUP)
      warmCnt_q <= warmLen(warmSel);
    else if (!warmDone)
      warmCnt_q <= warmCnt_q - 1'b1;
  end

  // The three pulses below are registered, one cycle long, and line up
  // with the first cycle of the new mode, or for a watchdog-blocked idle entry with the cycle after the write. Consumers may treat them as
  // strobes without edge detection of their own. A direct warm-up
  // entry gives the same entry clear; the clear at warm-up end still comes.

  // Divider clear pulse on a stop write taken in ST_NORMAL (halt or direct warm-up entry) and at warm-up end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      divClr_q <= 1'b0;
    else
      divClr_q <= (state_q == ST_NORMAL && stopReq)
                  || (state_q == ST_WARMUP && warmDone);
  end

  // Resume pulse: CPU continues at the held next address
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      resume_q <= 1'b0;
    else
      resume_q <= (state_q == ST_WARMUP && warmDone)
                  || (state_q == ST_IDLE && irqWake);
  end

  // Service request on idle wake when the master enable is set, or when the watchdog latch blocks idle entry
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      service_q <= 1'b0;
    else
      service_q <= (state_q == ST_IDLE && irqWake
                    && masterIrqEnable)
                   || (state_q == ST_NORMAL && idleReq && !stopReq
                       && irqPendingLatch[smc_pkg::WDT_IRQ_BIT]);
  end

  // Hold controls; CPU state is frozen, not reset, by these.
  // oscRun falls only in halt: warm-up needs the clock to count, so
  // the oscillator is already back on there. cpuHalt and wdtHalt cover
  // every standby mode. Port high impedance also spans warm-up, so the
  // pins do not glitch back to drive before the CPU resumes.
  // These are decoded straight from the state register, so they change
  // on the same edge as modeState and carry no extra delay.
  // Memory and port latches need no control here: a frozen CPU keeps them.
  always_comb
  begin
    hold.oscRun  = (state_q != ST_HALT);
    hold.cpuHalt = (state_q != ST_NORMAL);
    hold.wdtHalt = (state_q != ST_NORMAL);
    hold.portHiZ = (state_q == ST_HALT || state_q == ST_WARMUP)
                   && !ctrl1_q.portDriveDuringHalt;
  end

  assign dividerClear = divClr_q;
  assign resumeNext   = resume_q;
  assign irqService   = service_q;
  assign modeState    = state_q;

  // Read views; start bits report the live mode.
  // Reading back the live mode instead of the written bit means a read
  // made after release shows zero without software clearing anything.
  // The fixed bit of control 2 always reads one, as software expects.
  // Status packs the pin, the pending and effective release methods
  // and the mode, for debug and for the edge to level switch.
  always_comb
  begin
    ctrl1Read = 8'h00;
    ctrl1Read[smc_pkg::C1_STOP] = (state_q == ST_HALT)
                                  || (state_q == ST_WARMUP);
    ctrl1Read[smc_pkg::C1_RELEASE_SELECT] = ctrl1_q.releaseSelect;
    ctrl1Read[smc_pkg::C1_PORT] = ctrl1_q.portDriveDuringHalt;
    ctrl1Read[smc_pkg::C1_WUT_H:smc_pkg::C1_WUT_L] = ctrl1_q.warmupSelect;
    ctrl2Read = 8'h00;
    ctrl2Read[smc_pkg::C2_FIXED] = 1'b1;
    ctrl2Read[smc_pkg::C2_IDLE]  = (state_q == ST_IDLE);
    statusRead = {3'h0, wakePin, relPend_q, relEff_q, modeState};
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      unique case (avs_address)
        smc_pkg::OFF_CTRL1:  rdata_q <= {24'h00_0000, ctrl1Read};
        smc_pkg::OFF_CTRL2:  rdata_q <= {24'h00_0000, ctrl2Read};
        smc_pkg::OFF_STATUS: rdata_q <= {24'h00_0000, statusRead};
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

endmodule
`default_nettype wire

// [tb/smc_standby_monitor.sv]
// Purpose: Port assertions for the standby controller
// Assumes: Warm-up lengths come in as parameters
// Notes:   Bound into the controller, reset disables all
`default_nettype none
module smc_standby_monitor
#(
  parameter int WARM_LONG  = 12,
  parameter int WARM_SHORT = 4
)
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               wakePin,
  input wire logic [15:0]        irqPendingLatch,
  input wire logic [15:0]        sourceIrqEnable,
  input wire logic               masterIrqEnable,
  input wire smc_pkg::smc_hold_t hold,
  input wire logic               dividerClear,
  input wire logic               resumeNext,
  input wire logic               irqService,
  input wire logic [1:0]         modeState
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [21:0] warmCnt_q;
  // Cycles spent in warm-up, cleared outside it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || modeState != 2'h2)
      warmCnt_q <= 22'h0;
    else
      warmCnt_q <= warmCnt_q + 22'h1;
  end
  // Back in normal mode with resume pulse
  sequence s_back;
    modeState == 2'h0 && resumeNext;
  endsequence
  sequence s_resumed;
    s_back ##0 dividerClear;
  endsequence
  AST_HALT_OSC: assert property (modeState == 2'h1 |->
    !hold.oscRun && hold.cpuHalt) else $error("osc runs in halt");
  AST_HIZ_SCOPE: assert property (hold.portHiZ |->
    modeState inside {2'h1, 2'h2}) else $error("hi-z outside halt");
  AST_DIV_ENTRY: assert property (modeState == 2'h1 &&
    $past(modeState) == 2'h0 |-> dividerClear) else $error("no clear");
  AST_NO_WAKE_LOW: assert property (modeState == 2'h1 &&
    !wakePin |=> modeState == 2'h1) else $error("left halt, pin low");
  AST_NO_REHALT: assert property (modeState == 2'h2 |=>
    modeState != 2'h1) else $error("halt again in warm-up");
  AST_WARM_LEN: assert property ($fell(modeState == 2'h2) |->
    warmCnt_q == WARM_SHORT || warmCnt_q == WARM_LONG)
    else $error("warm-up length wrong");
  AST_RESUME: assert property ($fell(modeState == 2'h2) |->
    s_resumed) else $error("no resume after warm-up");
  AST_IDLE_HOLD: assert property (modeState == 2'h3 |->
    hold == 4'b1110) else $error("idle holds wrong");
  AST_IDLE_WAKE: assert property (modeState == 2'h3 &&
    (irqPendingLatch & sourceIrqEnable) != 16'h0 |=> s_back ##0
    irqService == $past(masterIrqEnable)) else $error("idle wake wrong");
endmodule
bind smc_standby_ctrl smc_standby_monitor
  #(.WARM_LONG(WARM_LONG), .WARM_SHORT(WARM_SHORT)) mon
  (.core_clk, .rst_n, .wakePin, .irqPendingLatch, .sourceIrqEnable,
   .masterIrqEnable, .hold, .dividerClear, .resumeNext, .irqService,
   .modeState);
`default_nettype wire

// [tb/smc_wake_src.sv]
// Purpose: Wake source on the stop pin
// Assumes: Pin changes just after a rising edge
// Notes:   Actively driven both ways, level held between calls
`default_nettype none
module smc_wake_src
(
  input  wire logic core_clk,
  output var  logic wakePin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wakePin = 1'b0;
  // Level for level release, edges for edge release
  task automatic drive(input logic v);
    @(posedge core_clk);
    wakePin <= v;
  endtask
  // Short high pulse, one rising edge
  task automatic pulse(input int n);
    drive(1'b1);
    repeat (n) @(posedge core_clk);
    wakePin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_standby_mode_controller.sv]
// Purpose: Self-checking bench for the standby controller
// Assumes: Warm-up counts shortened to 12 and 4
// Notes:   Bus waits on waitrequest, never on a fixed count
`default_nettype none
module tb_standby_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic               core_clk;
  logic               rst_n;
  logic [3:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               wakePin;
  logic [15:0]        irqPendingLatch;
  logic [15:0]        sourceIrqEnable;
  logic               masterIrqEnable;
  smc_pkg::smc_hold_t hold;
  logic               dividerClear;
  logic               resumeNext;
  logic               irqService;
  logic [1:0]         modeState;
  int                 errors;
  int                 num_checks;
  int                 n;
  logic [31:0]        v;
  smc_standby_ctrl #(.WARM_LONG(12), .WARM_SHORT(4)) dut
  (
    .core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .wakePin, .irqPendingLatch, .sourceIrqEnable,
    .masterIrqEnable, .hold, .dividerClear, .resumeNext, .irqService,
    .modeState
  );
  smc_wake_src src (.core_clk, .wakePin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      errors++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (modeState !== m && k < 100);
    chk(modeState, m);
  endtask
  // Counts warm-up cycles, then checks the resume pulses
  task automatic warm_len(input int exp);
    wait_mode(2'h2);
    n = 1;
    @(posedge core_clk);
    while (modeState === 2'h2)
    begin
      n++;
      @(posedge core_clk);
    end
    chk(n, exp);
    chk({resumeNext, dividerClear}, 2'b11);
  endtask
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog far beyond the 120 or so cycles needed
  initial
  begin
    #50000;
    errors++;
    end_of_test();
  end
  initial
  begin
    errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {irqPendingLatch, sourceIrqEnable, masterIrqEnable} = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h4, 32'h0, v);
    chk(v, 32'h80);
    bus(1'b0, 4'hC, 32'h0, v);
    chk(v, 32'h0);
    // Edge release with pin already high
    src.drive(1'b1);
    bus(1'b1, 4'h0, 32'h84, v);
    wait_mode(2'h1);
    chk(hold, 4'b0111);
    repeat (5) @(posedge core_clk);
    chk(modeState, 2'h1);
    src.drive(1'b0);
    fork
      src.pulse(2);
      warm_len(4);
    join
    // Level select stays pending until a rising edge
    bus(1'b1, 4'h0, 32'h40, v);
    bus(1'b0, 4'h8, 32'h0, v);
    chk(v, 32'h08);
    src.pulse(2);
    bus(1'b0, 4'h8, 32'h0, v);
    chk(v, 32'h04);
    bus(1'b1, 4'h0, 32'hD0, v);
    wait_mode(2'h1);
    chk(hold, 4'b0110);
    bus(1'b0, 4'h0, 32'h0, v);
    chk(v, 32'hD0);
    fork
      src.pulse(3);
      warm_len(12);
    join
    src.drive(1'b1);
    bus(1'b1, 4'h0, 32'hC4, v);
    #1 chk(modeState, 2'h2);
    warm_len(4);
    src.drive(1'b0);
    bus(1'b1, 4'h0, 32'hC0, v);
    wait_mode(2'h1);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(modeState, 2'h0);
    bus(1'b0, 4'h0, 32'h0, v);
    chk(v, 32'h0);
    // A write without lane 0 must leave the fields alone
    avs_byteenable <= 4'hE;
    bus(1'b1, 4'h0, 32'h40, v);
    avs_byteenable <= 4'hF;
    bus(1'b0, 4'h0, 32'h0, v);
    chk(v, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      masterIrqEnable <= m[0];
      bus(1'b1, 4'h4, 32'h90, v);
      wait_mode(2'h3);
      bus(1'b0, 4'h4, 32'h0, v);
      chk(v, 32'h90);
      irqPendingLatch <= 16'h0020;
      sourceIrqEnable <= 16'h0020;
      wait_mode(2'h0);
      chk({resumeNext, irqService}, {1'b1, m[0]});
      irqPendingLatch <= 16'h0000;
    end
    @(posedge core_clk);
    irqPendingLatch <= 16'h0004;
    bus(1'b1, 4'h4, 32'h90, v);
    #1 chk(modeState, 2'h0);
    chk(irqService, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
